// ===== src/cnvp_device.sv
// Notes on behaviour
// - fresh device starts in configuration mode
// - successful restore ends in reset, configuration mode
// - host writes config, then matching checksum
// - commit only on checksum match, else abort
// - successful commit issues a system reset
// - programming and restore finish within bound
// - counter increments per program, saturates 3fh
// - saturated counter never blocks reprogramming
// - status bit 7 shows program enable
// - status bit 6 low means fault
// - status bits 5:0 hold cycle count
// - crc over 10h..15h then 00h, 01h
// - reserved bits count as zero
// - crc8 poly 2fh, msb first, unreflected
// - final crc inverted before compare
// - crc start value is variant dependent
// - xor byte, eight shifts with conditional poly
// - restore needs reset low, lin dominant, battery above restore minimum, held
// - after restore wait recessive, then reset
// - restore also increments the counter
// - commit reset recorded as configured cause
// - restore reset recorded as its own cause
`timescale 1ns/1ps
`include "cnvp_params.svh"

module cnvp_device
  import cnvp_pkg::*;
#(
  parameter int PROG_CYCLES = `CNVP_PROG_TIME_NS / `CNVP_CLK_NS,
  parameter int RESTORE_CYCLES = (`CNVP_RESTORE_DELAY_NS + `CNVP_CLK_NS - 1) / `CNVP_CLK_NS,
  parameter int RST_CYCLES = (`CNVP_RST_PULSE_NS + `CNVP_CLK_NS - 1) / `CNVP_CLK_NS
) (
  input wire logic mclk, // 200 mhz clock
  input wire logic sys_rst, // battery power-on reset
  cnvp_if.dev link, // register port and pins
  output logic [47:0] cfg_active, // configuration registers, 10h in low byte
  output logic config_mode, // block in configuration mode
  output logic system_reset, // system reset in progress
  output logic [1:0] reset_cause, // cause of the last system reset
  output logic [5:0] program_cycle_count // nonvolatile program cycles
);

  // ==========================================================
  // pin synchronisers
  logic [2:0] s1_q, s2_q, s3_q, pin_q;
  // one edge past the sync chain, so pin_q already holds the pin levels
  logic [3:0] settle_q;
  wire [2:0] pin_raw = {link.bat_above_restore_min, link.lin_dominant, ~link.reset_line_n_in};
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
      pin_q <= 3'h0;
      settle_q <= 4'h0;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= (s2_q == s3_q) ? s3_q : pin_q;
      settle_q <= {settle_q[2:0], 1'b1};
    end
  end
  wire rst_low = pin_q[0];
  wire lin_dom = pin_q[1];
  wire bat_ok = pin_q[2];
  wire pins_settled = settle_q[3];

  // ==========================================================
  // state and storage
  cnvp_state_t state_q;
  logic [7:0] cfg_q [0:`CNVP_CFG_NUM-1];
  logic [7:0] nv_q [0:`CNVP_CFG_NUM-1];
  logic nv_programmed_q;
  logic fault_n_q;
  logic [5:0] cnt_q;
  logic [7:0] checksum_q;
  logic [7:0] crc_q;
  logic [2:0] idx_q;
  logic [22:0] timer_q;
  logic [1:0] cause_q;
  logic ack_q;
  logic [7:0] rdata_q;

  // ==========================================================
  // bus decode
  wire take = link.req & ~ack_q;
  wire wr_take = take & link.we;
  wire in_cfg_range = (link.addr >= `CNVP_ADDR_CFG_FIRST) && (link.addr <= `CNVP_ADDR_CFG_LAST);
  wire [2:0] cfg_idx = 3'(link.addr - `CNVP_ADDR_CFG_FIRST);
  wire cfg_wr = wr_take & in_cfg_range & (state_q == CNVP_S_CONFIG);
  wire chk_wr = wr_take & (link.addr == `CNVP_ADDR_CHECKSUM) & (state_q == CNVP_S_CONFIG);
  wire [7:0] status = {~nv_programmed_q, fault_n_q, cnt_q};
  wire [7:0] rd_mux = in_cfg_range ? cfg_q[cfg_idx] :
                      (link.addr == `CNVP_ADDR_CHECKSUM) ? checksum_q :
                      (link.addr == `CNVP_ADDR_STATUS) ? status : 8'h00;

  // ==========================================================
  // crc walk over six registers and two tail bytes
  wire [7:0] crc_in = (idx_q < 3'(`CNVP_CFG_NUM)) ? (cfg_q[idx_q] & cnvp_cfg_mask(idx_q)) :
                      (idx_q == 3'(`CNVP_CFG_NUM)) ? `CNVP_CRC_TAIL0 : `CNVP_CRC_TAIL1;
  wire [7:0] crc_next = cnvp_crc_byte(crc_q, crc_in);
  wire crc_match = ((crc_next ^ `CNVP_CRC_XOROUT) == checksum_q);
  wire [5:0] cnt_inc = (cnt_q == `CNVP_CNT_MAX) ? cnt_q : cnt_q + 6'h01;
  wire restore_cond = rst_low & lin_dom & bat_ok;
  wire prog_done = (timer_q == 23'(PROG_CYCLES - 1));
  wire rst_done = (timer_q == 23'(RST_CYCLES - 1));
  wire hold_done = (timer_q == 23'(RESTORE_CYCLES - 1));

  // ==========================================================
  // bus answer
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      ack_q <= take;
      rdata_q <= take ? rd_mux : rdata_q;
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < `CNVP_CFG_NUM; i++) begin
        cfg_q[i] <= `CNVP_CFG_PRESET;
      end
      checksum_q <= 8'h00;
    end else begin
      if (cfg_wr) begin
        cfg_q[cfg_idx] <= link.wdata & cnvp_cfg_mask(cfg_idx);
      end else if (state_q == CNVP_S_RESET && rst_done) begin
        for (int i = 0; i < `CNVP_CFG_NUM; i++) begin
          cfg_q[i] <= nv_q[i];
        end
      end
      if (chk_wr) begin
        checksum_q <= link.wdata;
      end
    end
  end

  // ==========================================================
  // control sequence
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= CNVP_S_POWERUP;
      for (int i = 0; i < `CNVP_CFG_NUM; i++) begin
        nv_q[i] <= `CNVP_CFG_PRESET;
      end
      nv_programmed_q <= 1'b0;
      fault_n_q <= 1'b1;
      cnt_q <= 6'h00;
      crc_q <= 8'h00;
      idx_q <= 3'h0;
      timer_q <= 23'h0;
      cause_q <= CNVP_CAUSE_POWER_ON;
    end else begin
      case (state_q)
        CNVP_S_POWERUP: begin
          if (pins_settled && restore_cond) begin
            timer_q <= hold_done ? 23'h0 : timer_q + 23'h1;
            state_q <= hold_done ? CNVP_S_RESTORE : CNVP_S_POWERUP;
          end else if (pins_settled) begin
            timer_q <= 23'h0;
            cause_q <= CNVP_CAUSE_POWER_ON;
            state_q <= CNVP_S_RESET;
          end
        end
        CNVP_S_CONFIG: begin
          if (chk_wr) begin
            crc_q <= `CNVP_CRC_INIT;
            idx_q <= 3'h0;
            state_q <= CNVP_S_CHECK;
          end
        end
        CNVP_S_CHECK: begin
          crc_q <= crc_next;
          idx_q <= idx_q + 3'h1;
          if (idx_q == `CNVP_CRC_LAST_IDX) begin
            timer_q <= 23'h0;
            fault_n_q <= crc_match;
            state_q <= crc_match ? CNVP_S_PROG : CNVP_S_CONFIG;
          end
        end
        CNVP_S_PROG: begin
          timer_q <= prog_done ? 23'h0 : timer_q + 23'h1;
          if (prog_done) begin
            for (int i = 0; i < `CNVP_CFG_NUM; i++) begin
              nv_q[i] <= cfg_q[i];
            end
            nv_programmed_q <= 1'b1;
            cnt_q <= cnt_inc;
            cause_q <= CNVP_CAUSE_CONFIGURED;
            state_q <= CNVP_S_RESET;
          end
        end
        CNVP_S_RESTORE: begin
          timer_q <= prog_done ? 23'h0 : timer_q + 23'h1;
          if (prog_done) begin
            for (int i = 0; i < `CNVP_CFG_NUM; i++) begin
              nv_q[i] <= `CNVP_CFG_PRESET;
            end
            nv_programmed_q <= 1'b0;
            fault_n_q <= 1'b1;
            cnt_q <= cnt_inc;
            state_q <= CNVP_S_WAIT_REC;
          end
        end
        CNVP_S_WAIT_REC: begin
          if (!lin_dom) begin
            cause_q <= CNVP_CAUSE_RESTORE;
            state_q <= CNVP_S_RESET;
          end
        end
        CNVP_S_RESET: begin
          timer_q <= rst_done ? 23'h0 : timer_q + 23'h1;
          if (rst_done) begin
            state_q <= nv_programmed_q ? CNVP_S_RUN : CNVP_S_CONFIG;
          end
        end
        CNVP_S_RUN: begin
          state_q <= CNVP_S_RUN;
        end
        default: begin
          state_q <= CNVP_S_RESET;
        end
      endcase
    end
  end

  // ==========================================================
  // outputs
  assign link.ack = ack_q;
  assign link.rdata = rdata_q;
  assign link.reset_line_n_dev_out = 1'b0;
  assign link.reset_line_n_dev_oe = (state_q == CNVP_S_RESET);
  assign cfg_active = {cfg_q[5], cfg_q[4], cfg_q[3], cfg_q[2], cfg_q[1], cfg_q[0]};
  assign config_mode = (state_q == CNVP_S_CONFIG) | (state_q == CNVP_S_CHECK);
  assign system_reset = (state_q == CNVP_S_RESET);
  assign reset_cause = cause_q;
  assign program_cycle_count = cnt_q;

endmodule : cnvp_device

// ===== src/cnvp_host.sv
`timescale 1ns/1ps
`include "cnvp_params.svh"

module cnvp_host
  import cnvp_pkg::*;
(
  input wire logic mclk, // 200 mhz clock
  input wire logic sys_rst, // asynchronous reset
  cnvp_if.host link, // register port and pins
  input wire logic cmd_valid, // single access request
  input wire logic cmd_we, // single access is a write
  input wire logic [7:0] cmd_addr, // single access address
  input wire logic [7:0] cmd_wdata, // single access write data
  input wire logic prog_start, // program cfg_values into the device
  input wire logic [47:0] cfg_values, // configuration, 10h in low byte
  output logic cmd_ready, // idle, takes cmd_valid or prog_start
  output logic rsp_valid, // access or program sequence finished
  output logic [7:0] rsp_rdata, // read data of a single access
  input wire logic hold_reset_low, // pull the reset line low
  input wire logic drive_lin_dominant, // hold the lin bus dominant
  input wire logic battery_ok, // battery above restore threshold
  output logic reset_line_low // synchronised reset line level
);

  // ==========================================================
  // checksum over the six values and tail bytes
  logic [7:0] crc_calc;
  always_comb begin
    crc_calc = `CNVP_CRC_INIT;
    for (int i = 0; i < `CNVP_CFG_NUM; i++) begin
      crc_calc = cnvp_crc_byte(crc_calc, cfg_values[i*8 +: 8] & cnvp_cfg_mask(3'(i)));
    end
    crc_calc = cnvp_crc_byte(crc_calc, `CNVP_CRC_TAIL0);
    crc_calc = cnvp_crc_byte(crc_calc, `CNVP_CRC_TAIL1);
    crc_calc = crc_calc ^ `CNVP_CRC_XOROUT;
  end

  // ==========================================================
  // sequencer
  cnvp_hstate_t state_q;
  logic [47:0] vals_q;
  logic [7:0] crc_q;
  logic [2:0] step_q;
  logic req_q, we_q, rsp_q;
  logic [7:0] addr_q, wdata_q, rdata_q;
  logic [2:0] sync_q;
  logic line_q;

  wire [7:0] step_addr = (step_q < 3'(`CNVP_CFG_NUM)) ? `CNVP_ADDR_CFG_FIRST + 8'(step_q) : `CNVP_ADDR_CHECKSUM;
  wire [7:0] step_data = (step_q < 3'(`CNVP_CFG_NUM)) ? vals_q[8'(step_q)*8 +: 8] : crc_q;
  wire last_step = (step_q == 3'(`CNVP_CFG_NUM));

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= CNVP_H_IDLE;
      vals_q <= 48'h0;
      crc_q <= 8'h00;
      step_q <= 3'h0;
      req_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      rsp_q <= 1'b0;
    end else begin
      rsp_q <= 1'b0;
      case (state_q)
        CNVP_H_IDLE: begin
          if (prog_start) begin
            vals_q <= cfg_values;
            crc_q <= crc_calc;
            step_q <= 3'h0;
            state_q <= CNVP_H_PROG;
          end else if (cmd_valid) begin
            req_q <= 1'b1;
            we_q <= cmd_we;
            addr_q <= cmd_addr;
            wdata_q <= cmd_wdata;
            state_q <= CNVP_H_SINGLE;
          end
        end
        CNVP_H_SINGLE: begin
          if (link.ack) begin
            req_q <= 1'b0;
            rdata_q <= link.rdata;
            rsp_q <= 1'b1;
            state_q <= CNVP_H_IDLE;
          end
        end
        CNVP_H_PROG: begin
          if (!req_q) begin
            req_q <= 1'b1;
            we_q <= 1'b1;
            addr_q <= step_addr;
            wdata_q <= step_data;
          end else if (link.ack) begin
            req_q <= 1'b0;
            step_q <= step_q + 3'h1;
            rsp_q <= last_step;
            state_q <= last_step ? CNVP_H_IDLE : CNVP_H_PROG;
          end
        end
        default: begin
          state_q <= CNVP_H_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // reset line synchroniser
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_q <= 3'h0;
      line_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], ~link.reset_line_n_in};
      line_q <= (sync_q[1] == sync_q[2]) ? sync_q[2] : line_q;
    end
  end

  assign link.req = req_q;
  assign link.we = we_q;
  assign link.addr = addr_q;
  assign link.wdata = wdata_q;
  assign link.reset_line_n_host_out = 1'b0;
  assign link.reset_line_n_host_oe = hold_reset_low;
  assign link.lin_dominant = drive_lin_dominant;
  assign link.bat_above_restore_min = battery_ok;
  assign cmd_ready = (state_q == CNVP_H_IDLE);
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;
  assign reset_line_low = line_q;

endmodule : cnvp_host

// ===== src/cnvp_if.sv
`timescale 1ns/1ps

interface cnvp_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  logic reset_line_n_dev_out;
  logic reset_line_n_dev_oe;
  logic reset_line_n_host_out;
  logic reset_line_n_host_oe;
  logic reset_line_n_in;
  logic lin_dominant;
  logic bat_above_restore_min;

  // open-drain wire: low while any driver pulls it low
  assign reset_line_n_in = ~((reset_line_n_dev_oe & ~reset_line_n_dev_out) |
                             (reset_line_n_host_oe & ~reset_line_n_host_out));

  modport dev (
    input req, we, addr, wdata, reset_line_n_in, lin_dominant, bat_above_restore_min,
    output ack, rdata, reset_line_n_dev_out, reset_line_n_dev_oe
  );

  modport host (
    output req, we, addr, wdata, reset_line_n_host_out, reset_line_n_host_oe, lin_dominant,
    output bat_above_restore_min,
    input ack, rdata, reset_line_n_in
  );
endinterface : cnvp_if

// ===== src/cnvp_params.svh
`ifndef CNVP_PARAMS_SVH
`define CNVP_PARAMS_SVH

`define CNVP_ADDR_CFG_FIRST 8'h10
`define CNVP_ADDR_CFG_LAST 8'h15
`define CNVP_ADDR_CHECKSUM 8'h30
`define CNVP_ADDR_STATUS 8'h31
`define CNVP_CFG_NUM 6
`define CNVP_CFG_PRESET 8'h00
`define CNVP_MASK_10 8'hff
`define CNVP_MASK_11 8'hff
`define CNVP_MASK_12 8'h01
`define CNVP_MASK_13 8'h0f
`define CNVP_MASK_14 8'hb7
`define CNVP_MASK_15 8'h3f
`define CNVP_CRC_POLY 8'h2f
`define CNVP_CRC_MSB 8'h80
`define CNVP_CRC_XOROUT 8'hff
`define CNVP_CRC_INIT 8'hff
`define CNVP_CRC_TAIL0 8'h00
`define CNVP_CRC_TAIL1 8'h01
`define CNVP_CRC_LAST_IDX 3'h7
`define CNVP_CNT_MAX 6'h3f
`define CNVP_STAT_PEN_BIT 7
`define CNVP_STAT_FAULT_BIT 6
`define CNVP_CLK_NS 5
`define CNVP_PROG_TIME_NS 10000000
`define CNVP_RESTORE_DELAY_NS 20000000
`define CNVP_RST_PULSE_NS 1000000

`endif

// ===== src/cnvp_pkg.sv
`include "cnvp_params.svh"

package cnvp_pkg;

  typedef enum logic [7:0] {
    CNVP_S_POWERUP = 8'h01,
    CNVP_S_CONFIG = 8'h02,
    CNVP_S_RUN = 8'h04,
    CNVP_S_CHECK = 8'h08,
    CNVP_S_PROG = 8'h10,
    CNVP_S_RESTORE = 8'h20,
    CNVP_S_WAIT_REC = 8'h40,
    CNVP_S_RESET = 8'h80
  } cnvp_state_t;

  typedef enum logic [2:0] {
    CNVP_H_IDLE = 3'h1,
    CNVP_H_SINGLE = 3'h2,
    CNVP_H_PROG = 3'h4
  } cnvp_hstate_t;

  typedef enum logic [1:0] {
    CNVP_CAUSE_POWER_ON = 2'h0,
    CNVP_CAUSE_CONFIGURED = 2'h1,
    CNVP_CAUSE_RESTORE = 2'h2
  } cnvp_cause_t;

  // one byte through the crc, msb first
  function automatic logic [7:0] cnvp_crc_byte(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] v;
    v = crc ^ data;
    for (int j = 0; j < 8; j++) begin
      if (v >= `CNVP_CRC_MSB) begin
        v = {v[6:0], 1'b0} ^ `CNVP_CRC_POLY;
      end else begin
        v = {v[6:0], 1'b0};
      end
    end
    return v;
  endfunction : cnvp_crc_byte

  // implemented bits of each configuration register, reserved bits zero
  function automatic logic [7:0] cnvp_cfg_mask(input logic [2:0] idx);
    case (idx)
      3'h0: return `CNVP_MASK_10;
      3'h1: return `CNVP_MASK_11;
      3'h2: return `CNVP_MASK_12;
      3'h3: return `CNVP_MASK_13;
      3'h4: return `CNVP_MASK_14;
      3'h5: return `CNVP_MASK_15;
      default: return 8'h00;
    endcase
  endfunction : cnvp_cfg_mask

endpackage : cnvp_pkg

// ===== verification/cnvp_asserts.sv
`timescale 1ns/1ps
`include "cnvp_params.svh"

module cnvp_asserts #(
  parameter int PROG_CYCLES = 20
) (
  input wire logic mclk, // clock
  input wire logic sys_rst, // async reset
  input wire logic req, // host request
  input wire logic we, // write access
  input wire logic [7:0] addr, // address
  input wire logic [7:0] wdata, // write data
  input wire logic ack, // device answer
  input wire logic [7:0] rdata, // read data
  input wire logic reset_line_n_dev_oe // device pulls reset line
);
  localparam int LO = PROG_CYCLES + 4;
  localparam int HI = PROG_CYCLES + 16;
  localparam logic [47:0] MASKS = {`CNVP_MASK_15, `CNVP_MASK_14, `CNVP_MASK_13, `CNVP_MASK_12,
    `CNVP_MASK_11, `CNVP_MASK_10};

  // ==========
  // shadow checksum
  function automatic logic [7:0] crc8(input logic [47:0] v);
    logic [63:0] s;
    logic [7:0] c;
    s = {`CNVP_CRC_TAIL1, `CNVP_CRC_TAIL0, v & MASKS};
    c = `CNVP_CRC_INIT;
    for (int i = 0; i < 8; i++) begin
      c = c ^ s[i*8 +: 8];
      for (int j = 0; j < 8; j++) begin
        c = c[7] ? ({c[6:0], 1'b0} ^ `CNVP_CRC_POLY) : {c[6:0], 1'b0};
      end
    end
    return c ^ `CNVP_CRC_XOROUT;
  endfunction : crc8

  logic [47:0] shadow_q;
  logic [7:0] last_addr_q;
  logic [7:0] quiet_q;
  logic [1:0] st_exp_q;
  logic armed_q;
  logic committed_q;
  logic fault_q;
  logic oe_q;
  wire take = req & ~ack;
  wire st_read = take & ~we & (addr == `CNVP_ADDR_STATUS);
  wire ck_write = take & we & armed_q & (addr == `CNVP_ADDR_CHECKSUM);
  wire crc_ok = (wdata == crc8(shadow_q));
  wire cfg_write = take & we & armed_q & (addr >= `CNVP_ADDR_CFG_FIRST) & (addr <= `CNVP_ADDR_CFG_LAST);
  wire [5:0] cfg_pos = 6'((addr - `CNVP_ADDR_CFG_FIRST) * 8'h08);
  // armed once the device leaves a reset while no good checksum has been written
  wire armed_d = (armed_q | (oe_q & ~reset_line_n_dev_oe & ~committed_q)) & ~(ck_write & crc_ok);
  wire [7:0] quiet_d = (ck_write & ~crc_ok) ? 8'(HI) : ((quiet_q != 8'h00) ? quiet_q - 8'h01 : quiet_q);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      shadow_q <= '0;
      last_addr_q <= '0;
      quiet_q <= '0;
      st_exp_q <= '0;
      armed_q <= 1'b0;
      committed_q <= 1'b0;
      fault_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      oe_q <= reset_line_n_dev_oe;
      armed_q <= armed_d;
      quiet_q <= quiet_d;
      committed_q <= committed_q | (ck_write & crc_ok);
      fault_q <= ck_write ? ~crc_ok : fault_q;
      if (take) last_addr_q <= addr;
      if (cfg_write) shadow_q[cfg_pos +: 8] <= wdata;
      if (st_read) st_exp_q <= {~committed_q, ~fault_q};
    end
  end

  // ==========
  // properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  property p_ack_follows; take |=> ack; endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("no ack after request");
  property p_ack_pulse; ack |=> !ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_req_held; take |=> req && $stable(we) && $stable(addr) && $stable(wdata); endproperty
  a_req_held: assert property (p_req_held) else $error("request changed before ack");
  property p_host_crc; take && we && addr == `CNVP_ADDR_CHECKSUM && last_addr_q == `CNVP_ADDR_CFG_LAST |-> crc_ok;
  endproperty
  a_host_crc: assert property (p_host_crc) else $error("host checksum wrong");
  property p_commit_reset; ck_write && crc_ok |-> ##[LO:HI] reset_line_n_dev_oe; endproperty
  a_commit_reset: assert property (p_commit_reset) else $error("no reset after commit");
  property p_mismatch_quiet; quiet_q != 8'h00 |-> !reset_line_n_dev_oe; endproperty
  a_mismatch_quiet: assert property (p_mismatch_quiet) else $error("reset after bad checksum");
  property p_reset_pulse; $rose(reset_line_n_dev_oe) |-> reset_line_n_dev_oe [*4] ##1 !reset_line_n_dev_oe;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse length wrong");
  property p_status_flags; st_read |=> rdata[7:6] == st_exp_q; endproperty
  a_status_flags: assert property (p_status_flags) else $error("status flags wrong");
endmodule : cnvp_asserts

// ===== verification/tb_config_nvm_program_crc.sv
`timescale 1ns/1ps
`include "cnvp_params.svh"

module tb_config_nvm_program_crc;
  localparam int PROG = 20;
  localparam logic [47:0] MASKS = {`CNVP_MASK_15, `CNVP_MASK_14, `CNVP_MASK_13, `CNVP_MASK_12,
    `CNVP_MASK_11, `CNVP_MASK_10};
  logic mclk, sys_rst, cmd_valid, cmd_we, prog_start, cmd_ready, rsp_valid;
  logic hold_reset_low, drive_lin_dominant, battery_ok, reset_line_low, config_mode, system_reset;
  logic [7:0] cmd_addr, cmd_wdata, rsp_rdata;
  logic [47:0] cfg_values, cfg_active, cfg;
  logic [1:0] reset_cause;
  logic [5:0] program_cycle_count;
  logic [8:0] notes[$];
  logic [8:0] note;
  int fails, n_checks;

  cnvp_if link();
  cnvp_device #(.PROG_CYCLES(PROG), .RESTORE_CYCLES(10), .RST_CYCLES(4)) i_cnvp_device (.mclk(mclk),
    .sys_rst(sys_rst), .link(link), .cfg_active(cfg_active), .config_mode(config_mode),
    .system_reset(system_reset), .reset_cause(reset_cause), .program_cycle_count(program_cycle_count));
  cnvp_host i_cnvp_host (.mclk(mclk), .sys_rst(sys_rst), .link(link), .cmd_valid(cmd_valid), .cmd_we(cmd_we),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .prog_start(prog_start), .cfg_values(cfg_values),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .hold_reset_low(hold_reset_low),
    .drive_lin_dominant(drive_lin_dominant), .battery_ok(battery_ok), .reset_line_low(reset_line_low));
  cnvp_asserts #(.PROG_CYCLES(PROG)) i_cnvp_asserts (.mclk(mclk), .sys_rst(sys_rst), .req(link.req),
    .we(link.we), .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata),
    .reset_line_n_dev_oe(link.reset_line_n_dev_oe));

  // ==========
  // helpers
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  function automatic logic flag(input int i);
    case (i)
      0: return cmd_ready;
      1: return config_mode;
      2: return system_reset;
      default: return rsp_valid;
    endcase
  endfunction : flag

  task automatic wait_for(input int i, input logic v, input int lim);
    int k;
    k = 0;
    while (flag(i) !== v && k < lim) begin
      tick(1);
      k++;
    end
    if (flag(i) !== v) begin
      fails++;
      $display("mismatch at %0t: wait %0d ran out", $time, i);
    end
  endtask : wait_for

  // single access, or program sequence when prog is set
  task automatic access(input logic prog, input logic we, input logic [7:0] a, input logic [8:0] nt);
    wait_for(0, 1'b1, 50);
    notes.push_back(nt);
    prog_start = prog;
    cfg_values = cfg;
    cmd_valid = ~prog;
    cmd_we = we;
    cmd_addr = a;
    tick(1);
    prog_start = 1'b0;
    cmd_valid = 1'b0;
    wait_for(3, 1'b1, 100);
    tick(1);
  endtask : access

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    access(1'b0, 1'b0, a, {1'b1, exp});
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cmd_wdata = d;
    access(1'b0, 1'b1, a, 9'h000);
  endtask : wr

  task automatic commit(input logic [5:0] cnt);
    cfg = 48'({$urandom, $urandom});
    access(1'b1, 1'b0, 8'h00, 9'h000);
    wait_for(2, 1'b1, PROG + 40);
    check(reset_cause, 48'h1);
    check(link.reset_line_n_in, 48'h0);
    check(program_cycle_count, 48'(cnt));
    tick(4);
    check(reset_line_low, 48'h1);
    wait_for(2, 1'b0, 100);
    check(config_mode, 48'h0);
    check(cfg_active, cfg & MASKS);
    rd(`CNVP_ADDR_STATUS, {2'b01, cnt});
  endtask : commit

  // ==========
  // result watcher
  always @(posedge mclk) begin
    if (rsp_valid === 1'b1) begin
      note = notes.pop_front();
      if (note[8]) check(rsp_rdata, note[7:0]);
    end
  end

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    repeat (4000) @(posedge mclk);
    fails++;
    $display("mismatch at %0t: run timed out", $time);
    tally_and_finish();
  end

  // ==========
  // scenarios
  initial begin
    {sys_rst, battery_ok} = 2'b11;
    {cmd_valid, cmd_we, prog_start, hold_reset_low, drive_lin_dominant} = '0;
    cmd_addr = 8'h00;
    cmd_wdata = 8'h00;
    cfg = '0;
    cfg_values = '0;
    fails = 0;
    n_checks = 0;
    void'($urandom(32'hb17b5ee3));
    tick(16);
    sys_rst = 1'b0;
    wait_for(1, 1'b1, 100);
    check(reset_cause, 48'h0);
    check(cfg_active, 48'h0);
    rd(`CNVP_ADDR_STATUS, 8'hc0);
    rd(8'h20, 8'h00);
    // bad checksum after config writes
    cfg = 48'({$urandom, $urandom});
    for (int i = 0; i < 6; i++) wr(8'h10 + 8'(i), cfg[i*8 +: 8]);
    rd(8'h12, cfg[23:16] & `CNVP_MASK_12);
    wr(`CNVP_ADDR_CHECKSUM, i_cnvp_asserts.crc8(cfg) ^ 8'h5a);
    tick(PROG + 20);
    check({config_mode, system_reset, program_cycle_count}, 48'h80);
    rd(`CNVP_ADDR_STATUS, 8'h80);
    commit(6'h01);
    // factory restore at power-up
    {sys_rst, hold_reset_low, drive_lin_dominant} = 3'b111;
    tick(4);
    sys_rst = 1'b0;
    tick(80);
    check({system_reset, program_cycle_count}, 48'h01);
    {hold_reset_low, drive_lin_dominant} = 2'b00;
    wait_for(2, 1'b1, 50);
    check(reset_cause, 48'h2);
    wait_for(1, 1'b1, 100);
    check(cfg_active, 48'h0);
    rd(`CNVP_ADDR_STATUS, 8'hc1);
    commit(6'h02);
    tally_and_finish();
  end
endmodule : tb_config_nvm_program_crc
